// ---- src/ptd_pkg.sv ----
// package for the pci target image decode block: offsets, fields, codes
// assumes a single 100 MHz clock and a synchronous active-high reset
`default_nettype none

package ptd_pkg;

  // ----------------------------------------------------------------
  // register offsets, as seen on the register access port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_MISC1 = 12'h003;
  localparam logic [ADDR_W-1:0] OFF_I0_BD = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_I0_CTL = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_I0_BS = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_I0_TO = 12'h10C;
  localparam logic [ADDR_W-1:0] OFF_I1_CTL = 12'h114;
  localparam logic [ADDR_W-1:0] OFF_I1_BS = 12'h118;
  localparam logic [ADDR_W-1:0] OFF_I1_BD = 12'h11C;
  localparam logic [ADDR_W-1:0] OFF_I1_TO = 12'h120;

  // ----------------------------------------------------------------
  // configuration byte fields and their fixed values
  // ----------------------------------------------------------------
  localparam int MAX_LAT_LSB = 24;
  localparam int MIN_GNT_LSB = 16;
  localparam int INT_PIN_LSB = 8;
  localparam logic [7:0] MAX_LAT_VAL = 8'h00;
  localparam logic [7:0] MIN_GNT_VAL = 8'h03;
  localparam logic [7:0] INT_PIN_VAL = 8'h01;
  localparam logic [7:0] INT_LINE_RST = 8'h00;
  localparam int MIN_GNT_UNIT_NS = 250;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_GNT_UNIT_CYC = (MIN_GNT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // image control field positions
  // ----------------------------------------------------------------
  localparam int CTL_EN = 31;
  localparam int CTL_POSTED_WRITE_ENABLE = 30;
  localparam int CTL_VDW_LSB = 22;
  localparam int CTL_VAS_LSB = 16;
  localparam int CTL_PGM = 14;
  localparam int CTL_SUPER = 12;
  localparam int CTL_VCT = 8;
  localparam int CTL_LAS = 0;
  localparam logic [31:0] CTL_WMASK = 32'hC0C7_5101;
  localparam logic [31:0] CTL_RST = 32'h0080_0000;
  localparam logic [1:0] VDW_RST = 2'b10;

  // ----------------------------------------------------------------
  // data width and address space codes
  // ----------------------------------------------------------------
  localparam logic [1:0] VDW_D8 = 2'b00;
  localparam logic [1:0] VDW_D16 = 2'b01;
  localparam logic [1:0] VDW_D32 = 2'b10;
  localparam logic [1:0] VDW_D64 = 2'b11;
  localparam logic [2:0] VAS_A16 = 3'b000;
  localparam logic [2:0] VAS_A24 = 3'b001;
  localparam logic [2:0] VAS_A32 = 3'b010;
  localparam logic [2:0] VAS_RSV3 = 3'b011;
  localparam logic [2:0] VAS_RSV4 = 3'b100;
  localparam logic [2:0] VAS_CRCSR = 3'b101;
  localparam logic [2:0] VAS_USER1 = 3'b110;
  localparam logic [2:0] VAS_USER2 = 3'b111;

  // ----------------------------------------------------------------
  // address modifier bases; low bits add program, supervisor, block
  // ----------------------------------------------------------------
  localparam logic [5:0] AM_A16_BASE = 6'h29;
  localparam logic [5:0] AM_A24_BASE = 6'h38;
  localparam logic [5:0] AM_A32_BASE = 6'h08;
  localparam logic [5:0] AM_CRCSR = 6'h2F;
  localparam logic [5:0] AM_USER1 = 6'h10;
  localparam logic [5:0] AM_USER2 = 6'h18;
  localparam logic [5:0] AM_NONE = 6'h00;

  // ----------------------------------------------------------------
  // image geometry and power-up sampling
  // ----------------------------------------------------------------
  localparam int NUM_IMG = 2;
  localparam int GRAN_4K_LSB = 12;
  localparam int GRAN_64K_LSB = 16;
  localparam int STRAP_W = 13;
  localparam int SYNC_STAGES = 3;

endpackage : ptd_pkg

`default_nettype wire

// ---- src/ptd_window.sv ----
// one image's address window compare and vme address translation
// assumes base, bound and offset are already masked to the granularity
`default_nettype none

module ptd_window #(
  parameter int LSB = 12
) (
  input wire logic en,
  input wire logic space_io,
  input wire logic [31:0] base,
  input wire logic [31:0] bound,
  input wire logic [31:0] offset,
  input wire logic [31:0] pci_addr,
  input wire logic pci_io,
  output logic hit,
  output logic [31:0] vme_addr
);
  import ptd_pkg::*;

  logic [31-LSB:0] a_hi;
  logic ge_base;
  logic lt_bound;
  logic open_top;

  assign a_hi = pci_addr[31:LSB];
  assign ge_base = a_hi >= base[31:LSB];
  assign lt_bound = a_hi < bound[31:LSB];
  assign open_top = bound[31:LSB] == '0;
  // io cycles only match io images, memory cycles memory images
  assign hit = en && (pci_io == space_io) && ge_base && (open_top || lt_bound);
  // wraps modulo 2^32 so a negative offset maps downward
  assign vme_addr = {a_hi + offset[31:LSB], pci_addr[LSB-1:0]};

endmodule : ptd_window

`default_nettype wire

// ---- src/ptd_target.sv ----
// pci target image decode: config misc byte fields, two images, cycle attributes
// assumes register strobes and pci requests come from logic on the same clock;
// power-up option pins are asynchronous and are resampled here
//
// Functional notes
// - minimum grant reads fixed three, unit 250 ns, read only
// - maximum latency reads fixed zero, read only
// - interrupt pin reads fixed one, read only
// - interrupt line byte is read/write, resets zero, drives nothing
// - data width code selects 8/16/32/64 bits, resets to 32-bit
// - address space codes A16/A24/A32, CR/CSR, two user; 011,100 reserved
// - supervisor bit set gives supervisor modifiers in A16/A24/A32, clear non-privileged
// - block enable allows single blocks only in A24/A32 at 8/16/32 bits
// - A24/A32 with 64-bit width allows multiplexed blocks regardless of enable
// - space select clear answers memory cycles, set answers io cycles
// - io images ignore posted write enable; all transfers coupled
// - enabled image claims base <= address < bound
// - bound zero means no upper limit above base
// - 4 Kbyte granularity image 0, 64 Kbyte image 1
// - vme address high bits are pci address plus translation offset
`default_nettype none

module ptd_target (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ptd_pkg::STRAP_W-1:0] strap_pins,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ptd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic pci_req,
  input wire logic [31:0] pci_addr,
  input wire logic pci_io,
  output logic tgt_valid,
  output logic tgt_hit,
  output logic tgt_img,
  output logic [31:0] vme_addr,
  output logic [5:0] vme_am,
  output logic [1:0] vme_dw,
  output logic vme_blt,
  output logic vme_mblt,
  output logic vme_posted,
  output logic vme_space_err
);
  import ptd_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~m) | (nw & m);
  endfunction : merge_be

  function automatic logic is_a24_a32(input logic [2:0] vme_address_space);
    return (vme_address_space == VAS_A24) || (vme_address_space == VAS_A32);
  endfunction : is_a24_a32

  function automatic logic [31:0] gran_mask(input int img);
    return img == 0 ? 32'hFFFF_F000 : 32'hFFFF_0000;
  endfunction : gran_mask

  function automatic logic [5:0] am_code(input logic [2:0] vme_address_space, input logic program_data_attribute, input logic sup,
                                         input logic blt, input logic mblt);
    logic [5:0] low;
    low = {3'b000, sup, 2'b00};
    if (mblt) begin
      low[1:0] = 2'b00;
    end else if (blt) begin
      low[1:0] = 2'b11;
    end else begin
      low[1:0] = program_data_attribute ? 2'b10 : 2'b01;
    end
    unique case (vme_address_space)
      VAS_A16: return AM_A16_BASE | {3'b000, sup, 2'b00};
      VAS_A24: return AM_A24_BASE | low;
      VAS_A32: return AM_A32_BASE | low;
      VAS_CRCSR: return AM_CRCSR;
      VAS_USER1: return AM_USER1;
      VAS_USER2: return AM_USER2;
      default: return AM_NONE;
    endcase
  endfunction : am_code

  // ----------------------------------------------------------------
  // power-up option sampling
  // ----------------------------------------------------------------
  // not reset on purpose: reset must be able to load the sampled value
  logic [STRAP_W-1:0] strap_s1_r;
  logic [STRAP_W-1:0] strap_s2_r;
  logic [STRAP_W-1:0] strap_s3_r;
  logic [STRAP_W-1:0] strap_r;

  always_ff @(posedge clock) begin
    strap_s1_r <= strap_pins;
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
  end

  always_ff @(posedge clock) begin
    if (strap_s2_r == strap_s3_r) begin
      strap_r <= strap_s3_r;
    end
  end

  // strap layout: en, vas[2:0], las, base top nibble, bound top nibble
  logic strap_en;
  logic [2:0] strap_vas;
  logic strap_las;
  logic [3:0] strap_bs_hi;
  logic [3:0] strap_bd_hi;
  assign strap_en = strap_r[12];
  assign strap_vas = strap_r[11:9];
  assign strap_las = strap_r[8];
  assign strap_bs_hi = strap_r[7:4];
  assign strap_bd_hi = strap_r[3:0];

  // ----------------------------------------------------------------
  // image registers
  // ----------------------------------------------------------------
  logic [31:0] ctl_r [NUM_IMG];
  logic [31:0] bs_r [NUM_IMG];
  logic [31:0] bd_r [NUM_IMG];
  logic [31:0] to_r [NUM_IMG];
  logic [7:0] int_line_r;

  logic [ADDR_W-1:0] off_ctl [NUM_IMG];
  logic [ADDR_W-1:0] off_bs [NUM_IMG];
  logic [ADDR_W-1:0] off_bd [NUM_IMG];
  logic [ADDR_W-1:0] off_to [NUM_IMG];
  assign off_ctl[0] = OFF_I0_CTL;
  assign off_bs[0] = OFF_I0_BS;
  assign off_bd[0] = OFF_I0_BD;
  assign off_to[0] = OFF_I0_TO;
  assign off_ctl[1] = OFF_I1_CTL;
  assign off_bs[1] = OFF_I1_BS;
  assign off_bd[1] = OFF_I1_BD;
  assign off_to[1] = OFF_I1_TO;

  logic [NUM_IMG-1:0] win_hit;
  logic [31:0] win_vaddr [NUM_IMG];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IMG; gi++) begin : g_img
      logic [31:0] ctl_rst;
      logic [31:0] bs_rst;
      logic [31:0] bd_rst;
      if (gi == 0) begin : g_strap
        assign ctl_rst = (32'(strap_en) << CTL_EN) | (32'(VDW_RST) << CTL_VDW_LSB)
                       | (32'(strap_vas) << CTL_VAS_LSB) | (32'(strap_las) << CTL_LAS);
        assign bs_rst = {strap_bs_hi, 28'h000_0000};
        assign bd_rst = {strap_bd_hi, 28'h000_0000};
      end else begin : g_plain
        assign ctl_rst = CTL_RST;
        assign bs_rst = 32'h0000_0000;
        assign bd_rst = 32'h0000_0000;
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          ctl_r[gi] <= ctl_rst;
        end else if (reg_wr && reg_addr == off_ctl[gi]) begin
          ctl_r[gi] <= merge_be(ctl_r[gi], reg_wdata, reg_be, CTL_WMASK);
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          bs_r[gi] <= bs_rst;
          bd_r[gi] <= bd_rst;
          to_r[gi] <= 32'h0000_0000;
        end else if (reg_wr) begin
          if (reg_addr == off_bs[gi]) begin
            bs_r[gi] <= merge_be(bs_r[gi], reg_wdata, reg_be, gran_mask(gi));
          end
          if (reg_addr == off_bd[gi]) begin
            bd_r[gi] <= merge_be(bd_r[gi], reg_wdata, reg_be, gran_mask(gi));
          end
          if (reg_addr == off_to[gi]) begin
            to_r[gi] <= merge_be(to_r[gi], reg_wdata, reg_be, gran_mask(gi));
          end
        end
      end

      ptd_window #(
        .LSB(gi == 0 ? GRAN_4K_LSB : GRAN_64K_LSB)
      ) u_win (
        .en(ctl_r[gi][CTL_EN]),
        .space_io(ctl_r[gi][CTL_LAS]),
        .base(bs_r[gi]),
        .bound(bd_r[gi]),
        .offset(to_r[gi]),
        .pci_addr(pci_addr),
        .pci_io(pci_io),
        .hit(win_hit[gi]),
        .vme_addr(win_vaddr[gi])
      );
    end
  endgenerate

  // routing byte only; nothing in the block looks at it
  always_ff @(posedge clock) begin
    if (rst) begin
      int_line_r <= INT_LINE_RST;
    end else if (reg_wr && reg_addr == OFF_MISC1 && reg_be[0]) begin
      int_line_r <= reg_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (reg_addr == OFF_MISC1) begin
      rd_nxt = {MAX_LAT_VAL, MIN_GNT_VAL, INT_PIN_VAL, int_line_r};
    end
    for (int i = 0; i < NUM_IMG; i++) begin
      if (reg_addr == off_ctl[i]) begin
        rd_nxt = ctl_r[i];
      end
      if (reg_addr == off_bs[i]) begin
        rd_nxt = bs_r[i];
      end
      if (reg_addr == off_bd[i]) begin
        rd_nxt = bd_r[i];
      end
      if (reg_addr == off_to[i]) begin
        rd_nxt = to_r[i];
      end
    end
  end

  // unmapped offsets read as zero
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // claim and cycle attributes
  // ----------------------------------------------------------------
  // image 0 wins an overlap; overlapping windows are a software error
  logic sel_img;
  logic sel_hit;
  logic [31:0] sel_ctl;
  logic [2:0] sel_vas;
  logic [1:0] sel_dw;
  logic sel_blt;
  logic sel_mblt;
  assign sel_hit = |win_hit;
  assign sel_img = !win_hit[0];
  assign sel_ctl = ctl_r[sel_img];
  assign sel_vas = sel_ctl[CTL_VAS_LSB +: 3];
  assign sel_dw = sel_ctl[CTL_VDW_LSB +: 2];
  assign sel_blt = sel_ctl[CTL_VCT] && is_a24_a32(sel_vas) && (sel_dw != VDW_D64);
  assign sel_mblt = is_a24_a32(sel_vas) && (sel_dw == VDW_D64);

  always_ff @(posedge clock) begin
    if (rst) begin
      tgt_valid <= 1'b0;
    end else begin
      tgt_valid <= pci_req;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tgt_hit <= 1'b0;
      tgt_img <= 1'b0;
      vme_addr <= 32'h0000_0000;
      vme_am <= AM_NONE;
      vme_dw <= VDW_RST;
      vme_blt <= 1'b0;
      vme_mblt <= 1'b0;
      vme_posted <= 1'b0;
      vme_space_err <= 1'b0;
    end else if (pci_req) begin
      tgt_hit <= sel_hit;
      tgt_img <= sel_img;
      vme_addr <= win_vaddr[sel_img];
      vme_am <= am_code(sel_vas, sel_ctl[CTL_PGM], sel_ctl[CTL_SUPER], sel_blt, sel_mblt);
      vme_dw <= sel_dw;
      vme_blt <= sel_hit && sel_blt;
      vme_mblt <= sel_hit && sel_mblt;
      vme_posted <= sel_hit && sel_ctl[CTL_POSTED_WRITE_ENABLE] && !sel_ctl[CTL_LAS];
      vme_space_err <= sel_hit && (sel_vas == VAS_RSV3 || sel_vas == VAS_RSV4);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [19:0] chk_vaddr0;
  logic [15:0] chk_vaddr1;
  logic chk_in0;
  logic chk_is_misc;
  assign chk_vaddr0 = pci_addr[31:12] + to_r[0][31:12];
  assign chk_vaddr1 = pci_addr[31:16] + to_r[1][31:16];
  assign chk_is_misc = reg_rd && reg_addr == OFF_MISC1;
  assign chk_in0 = ctl_r[0][CTL_EN] && (pci_io == ctl_r[0][CTL_LAS]) && (pci_addr[31:12] >= bs_r[0][31:12])
                 && (bd_r[0][31:12] == 20'h0_0000 || pci_addr[31:12] < bd_r[0][31:12]);

  a_misc_fixed:
    assert property (chk_is_misc |=> reg_rvalid && reg_rdata[31:8] == 24'h00_0301)
      else $error("fixed config bytes wrong");
  a_max_lat_zero:
    assert property (reg_rvalid && $past(chk_is_misc) |-> reg_rdata[31:24] == 8'h00)
      else $error("max latency not zero");
  a_int_pin_one:
    assert property (reg_rvalid && $past(chk_is_misc) |-> reg_rdata[15:8] == 8'h01)
      else $error("interrupt pin not one");
  a_int_line_rw:
    assert property (reg_wr && reg_addr == OFF_MISC1 && reg_be[0] |=> int_line_r == $past(reg_wdata[7:0]))
      else $error("interrupt line write lost");
  a_claim_window:
    assert property (pci_req && chk_in0 |=> tgt_hit && !tgt_img)
      else $error("image 0 window not claimed");
  a_open_bound:
    assert property (pci_req && !win_hit[1] && !chk_in0 |=> !tgt_hit)
      else $error("address claimed outside image 0 window");
  a_xlate_img0:
    assert property (pci_req && chk_in0 |=> vme_addr[31:12] == $past(chk_vaddr0) &&
                     vme_addr[11:0] == $past(pci_addr[11:0]))
      else $error("image 0 translation wrong");
  a_xlate_img1:
    assert property (pci_req && !chk_in0 && win_hit[1] |=> tgt_img && vme_addr[31:16] == $past(chk_vaddr1) &&
                     vme_addr[15:0] == $past(pci_addr[15:0]))
      else $error("image 1 translation wrong");
  a_io_coupled:
    assert property (tgt_valid && vme_posted |-> !$past(sel_ctl[CTL_LAS]) && $past(sel_ctl[CTL_POSTED_WRITE_ENABLE]))
      else $error("posted write through io image");
  a_io_space:
    assert property (tgt_valid && tgt_hit |-> $past(pci_io) == $past(sel_ctl[CTL_LAS]))
      else $error("cycle space mismatch on claim");
  a_blt_gate:
    assert property (tgt_valid && vme_blt |-> $past(sel_ctl[CTL_VCT]) && $past(sel_dw) != VDW_D64 &&
                     (vme_am == 6'h3B || vme_am == 6'h3F || vme_am == 6'h0B || vme_am == 6'h0F))
      else $error("block transfer outside allowed modes");
  a_mblt_any:
    assert property (tgt_valid && tgt_hit && $past(sel_dw) == VDW_D64 && $past(is_a24_a32(sel_vas))
                     |-> vme_mblt && !vme_blt && vme_am[1:0] == 2'b00)
      else $error("64-bit block not offered");
  a_dw_follow:
    assert property (tgt_valid |-> vme_dw == $past(sel_dw))
      else $error("data width not from image");
  a_am_attr:
    assert property (tgt_valid && tgt_hit && !vme_blt && !vme_mblt && $past(is_a24_a32(sel_vas))
                     |-> vme_am[1:0] == ($past(sel_ctl[CTL_PGM]) ? 2'b10 : 2'b01))
      else $error("program/data modifier wrong");
  a_am_super:
    assert property (tgt_valid && tgt_hit && $past(sel_vas) <= VAS_A32 |-> vme_am[2] == $past(sel_ctl[CTL_SUPER]))
      else $error("privilege modifier wrong");
  a_resv_space:
    assert property (tgt_valid && tgt_hit |-> vme_space_err == ($past(sel_vas) == VAS_RSV3 ||
                     $past(sel_vas) == VAS_RSV4))
      else $error("reserved space not flagged");
  a_strap_load:
    assert property ($past(rst) |-> ctl_r[0][CTL_EN] == $past(strap_en) &&
                     ctl_r[0][CTL_VAS_LSB +: 3] == $past(strap_vas) && bs_r[0][31:28] == $past(strap_bs_hi))
      else $error("power-up options not loaded");

  c_hit_img0: cover property (tgt_valid && tgt_hit && !tgt_img);
  c_hit_img1: cover property (tgt_valid && tgt_hit && tgt_img);
  c_miss: cover property (tgt_valid && !tgt_hit);
  c_mblt: cover property (tgt_valid && vme_mblt);

endmodule : ptd_target

`default_nettype wire

// ---- testbench/ptd_pci_init.sv ----
// partner model: pci initiator that turns bench requests into decode pulses
// assumes bench raises go for one cycle, changed just after a rising edge
`default_nettype none

module ptd_pci_init (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [31:0] go_addr,
  input wire logic go_io,
  output logic pci_req,
  output logic [31:0] pci_addr,
  output logic pci_io
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // request launch
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pci_req <= 1'b0;
      pci_addr <= 32'h0000_0000;
      pci_io <= 1'b0;
    end else begin
      pci_req <= go;
      // released lines churn so a stale address never looks live
      pci_addr <= go ? go_addr : ~pci_addr;
      pci_io <= go ? go_io : ~pci_io;
    end
  end
endmodule : ptd_pci_init

`default_nettype wire

// ---- testbench/tb_top.sv ----
// bench top: register and decode checks of the pci target image block
// assumes straps steady from time zero and results in request order
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ptd_pkg::*;
  logic clock, rst, reg_wr, reg_rd, reg_rvalid, go, go_io, pci_req, pci_io;
  logic tgt_valid, tgt_hit, tgt_img, vme_blt, vme_mblt, vme_posted, vme_space_err;
  logic [12:0] strap_pins;
  logic [11:0] reg_addr;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata, reg_rdata, go_addr, pci_addr, vme_addr, c, t, a;
  logic [5:0] vme_am;
  logic [1:0] vme_dw;
  logic [45:0] dq[$], dm[$], m, dv;
  logic [31:0] rq[$];
  int err_count, tests_run, seed;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  ptd_target i_dut (.clock(clock), .rst(rst), .strap_pins(strap_pins), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pci_req(pci_req), .pci_addr(pci_addr), .pci_io(pci_io),
    .tgt_valid(tgt_valid), .tgt_hit(tgt_hit), .tgt_img(tgt_img), .vme_addr(vme_addr), .vme_am(vme_am),
    .vme_dw(vme_dw), .vme_blt(vme_blt), .vme_mblt(vme_mblt), .vme_posted(vme_posted),
    .vme_space_err(vme_space_err));
  ptd_pci_init i_init (.clock(clock), .rst(rst), .go(go), .go_addr(go_addr), .go_io(go_io),
    .pci_req(pci_req), .pci_addr(pci_addr), .pci_io(pci_io));
  always #5 clock = ~clock;
  // ----------------------------------------------------------------
  // reference and drivers
  // ----------------------------------------------------------------
  function automatic logic [11:0] attr(input logic [31:0] k);
    logic [2:0] s;
    logic [1:0] w;
    logic ab, mb, bl;
    logic [5:0] am;
    s = k[CTL_VAS_LSB +: 3];
    w = k[CTL_VDW_LSB +: 2];
    ab = (s == VAS_A24) || (s == VAS_A32);
    mb = ab && (w == VDW_D64);
    bl = ab && k[CTL_VCT] && (w != VDW_D64);
    case (s)
      VAS_A16: am = 6'h29 | {3'b000, k[CTL_SUPER], 2'b00};
      VAS_A24, VAS_A32: am = ((s == VAS_A24) ? 6'h38 : 6'h08) |
        {3'b000, k[CTL_SUPER], mb ? 2'b00 : bl ? 2'b11 : k[CTL_PGM] ? 2'b10 : 2'b01};
      VAS_CRCSR: am = 6'h2F;
      VAS_USER1: am = 6'h10;
      VAS_USER2: am = 6'h18;
      default: am = 6'h00;
    endcase
    return {am, w, bl, mb, k[CTL_POSTED_WRITE_ENABLE] & ~k[CTL_LAS], (s == VAS_RSV3) || (s == VAS_RSV4)};
  endfunction : attr

  task automatic chk(input logic [45:0] seen, input logic [45:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic reg_op(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] be);
    if (!w) rq.push_back(d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= ad;
    reg_wdata <= d;
    reg_be <= be;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : reg_op

  task automatic dec(input logic [31:0] ad, input logic io, input logic img, input logic [31:0] to,
                     input logic [31:0] ctl, input logic h);
    logic [31:0] va;
    va = img ? {ad[31:16] + to[31:16], ad[15:0]} : {ad[31:12] + to[31:12], ad[11:0]};
    dq.push_back(h ? {h, img, va, attr(ctl)} : 46'h0);
    // a miss only promises the hit bit and the cleared flags
    dm.push_back(h ? {46{1'b1}} : {1'b1, 41'h0, 4'hF});
    @(posedge clock);
    go <= 1'b1;
    go_addr <= ad;
    go_io <= io;
    @(posedge clock);
    go <= 1'b0;
  endtask : dec

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // monitor, watchdog, sequence
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (reg_rvalid === 1'b1) chk({14'h0, reg_rdata}, {14'h0, rq.pop_front()});
    if (tgt_valid === 1'b1) begin
      m = dm.pop_front();
      dv = {tgt_hit, tgt_img, vme_addr, vme_am, vme_dw, vme_blt, vme_mblt, vme_posted, vme_space_err};
      chk(dv & m, dq.pop_front() & m);
    end
  end

  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    conclude();
  end

  initial begin
    clock = 0;
    rst = 1;
    {reg_wr, reg_rd, go, go_io, reg_addr, reg_wdata, go_addr} = '0;
    reg_be = 4'h0;
    strap_pins = 13'h1412;
    seed = $urandom(32'h6f49_e77e);
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    reg_op(0, OFF_MISC1, 32'h0003_0100, 4'hF);
    reg_op(1, OFF_MISC1, 32'hFFFF_FF5A, 4'hF);
    reg_op(0, OFF_MISC1, 32'h0003_015A, 4'hF);
    reg_op(1, OFF_MISC1, 32'h0000_00C3, 4'hE);
    reg_op(0, OFF_MISC1, 32'h0003_015A, 4'hF);
    reg_op(0, OFF_I1_CTL, 32'h0080_0000, 4'hF);
    reg_op(0, 12'h200, 32'h0000_0000, 4'hF);
    reg_op(0, OFF_I0_CTL, 32'h8082_0000, 4'hF);
    reg_op(0, OFF_I0_BS, 32'h1000_0000, 4'hF);
    reg_op(0, OFF_I0_BD, 32'h2000_0000, 4'hF);
    reg_op(1, OFF_I0_TO, 32'hF010_0FFF, 4'hF);
    reg_op(0, OFF_I0_TO, 32'hF010_0000, 4'hF);
    dec(32'h1000_0000, 0, 0, 32'hF010_0000, 32'h8082_0000, 1);
    dec(32'h1FFF_FABC, 0, 0, 32'hF010_0000, 32'h8082_0000, 1);
    dec(32'h2000_0000, 0, 0, 0, 0, 0);
    dec(32'h0FFF_FFFF, 0, 0, 0, 0, 0);
    dec(32'h1000_0000, 1, 0, 0, 0, 0);
    reg_op(1, OFF_I1_BS, 32'h4000_FFFF, 4'hF);
    reg_op(0, OFF_I1_BS, 32'h4000_0000, 4'hF);
    for (int i = 0; i < 48; i++) begin
      c = $urandom() | 32'h8000_0000;
      t = $urandom();
      a = 32'h4000_0000 | $urandom();
      reg_op(1, OFF_I1_CTL, c, 4'hF);
      reg_op(0, OFF_I1_CTL, c & 32'hC0C7_5101, 4'hF);
      reg_op(1, OFF_I1_TO, t, 4'hF);
      dec(a, c[CTL_LAS], 1, t & 32'hFFFF_0000, c, 1);
      dec(a, ~c[CTL_LAS], 0, 0, 0, 0);
    end
    reg_op(1, OFF_I0_CTL, 32'h0002_0000, 4'hF);
    dec(32'h1000_0000, 0, 0, 0, 0, 0);
    repeat (4) @(posedge clock);
    if (rq.size() + dq.size() != 0) err_count++;
    conclude();
  end
endmodule : tb_top

`default_nettype wire
